// ### rtl/global_access_sync_control.sv
// global host access, channel steering and pin alignment control
// assumes host port pins and alignment pins arrive asynchronously to clk
//
// Contract
// - sync bit skips the extra host clock edge wait; host strobes are resynchronized in both modes
// - synchronous mode finishes accesses in fewer edges
// - accept host access only on identity match
// - width bit picks 8 or 16 bit bus
// - channel writes update every access-selected channel
// - multiple selected channels receive identical data
// - reads return lowest selected channel
// - channel enables gate logic, zero after reset
// - start event never starts a disabled channel
// - global hop enable gates pin hop events
// - global start enable gates pin start events
// - first-only bit ignores events after first
// - edge bit picks rising edge or level
// - per-pin enables admit each alignment pin
`timescale 1ns/1ps
`default_nettype none
module global_access_sync_control
	import access_sync_pkg::*;
#(
	parameter int NCH = NUM_CH
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// host microport
	input  wire logic                     host_side_clock,
	input  wire host_ctrl_t               host_ctrl,
	input  wire logic [7:0]               host_addr,
	input  wire logic [15:0]              host_data_in,
	output var  logic [15:0]              host_data_out,
	output var  logic                     host_data_oe,
	output var  logic                     host_ack,
	input  wire logic [3:0]               device_identity_pins,
	// alignment pins
	input  wire logic                     align_input_0,
	input  wire logic                     align_input_1,
	input  wire logic                     align_input_2,
	input  wire logic                     align_input_3,
	// per-channel alignment setup
	input  wire logic [NCH-1:0]           chan_pin_sync_on,
	input  wire logic [NCH*PIN_SELW-1:0]  chan_pin_select,
	// channel controls
	output var  logic [NCH-1:0]           channel_enable,
	output var  logic [NCH-1:0]           hop_pulse,
	output var  logic [NCH-1:0]           start_pulse
);
	// registers
	logic [7:0]     chip_cfg_reg;
	logic [NCH-1:0] chan_acc_reg;
	logic [NCH-1:0] chan_en_reg;
	logic [7:0]     pin_cfg_reg;
	// channel copies carry no reset and power up undefined
	logic [7:0]     chan_mem [NCH][CH_DEPTH];

	// synchronized host pins
	localparam int HW = 3 + 8 + 16 + 4;
	logic [HW-1:0] host_sync;
	logic          hclk_rise;
	host_ctrl_t    ctrl_s;
	logic [7:0]    addr_s;
	logic [15:0]   data_s;
	logic [3:0]    id_s;

	host_port_sync #(
		.W(HW)
	) u_host_sync (
		.clk             (clk),
		.rst             (rst),
		.host_side_clock (host_side_clock),
		.pins_in         ({host_ctrl, host_addr, host_data_in, device_identity_pins}),
		.pins_sync       (host_sync),
		.host_clk_rise   (hclk_rise)
	);

	assign ctrl_s = host_sync[HW-1 -: 3];
	assign addr_s = host_sync[27:20];
	assign data_s = host_sync[19:4];
	assign id_s   = host_sync[3:0];

	// synchronizers leave reset reading an active-low request and may show a
	// false host clock edge, so host decoding waits until they are refilled
	logic [3:0] settle_reg;
	logic       host_ready;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			settle_reg <= 4'h0;
		end else begin
			settle_reg <= {settle_reg[2:0], 1'b1};
		end
	end

	assign host_ready = settle_reg[3];

	// access decode
	logic id_match;
	logic req_active;
	logic wide_bus;
	logic sync_port;

	assign id_match   = (chip_cfg_reg[ID_MSB:ID_LSB] == id_s);
	assign req_active = ~ctrl_s.select_n & ~ctrl_s.strobe_n & id_match & host_ready;
	assign wide_bus   = chip_cfg_reg[WIDE_BUS_BIT];
	assign sync_port  = chip_cfg_reg[SYNC_PORT_BIT];

	// host access state machine
	host_state_t state_reg;
	host_state_t state_next;
	logic [1:0]  hold_cnt_reg;
	logic        do_access;

	always_comb begin
		state_next = state_reg;
		do_access  = 1'b0;
		case (state_reg)
			HS_IDLE: begin
				if (hclk_rise && req_active) begin
					if (sync_port) begin
						do_access  = 1'b1;
						state_next = HS_DONE;
					end else begin
						state_next = HS_WAIT;
					end
				end
			end
			HS_WAIT: begin
				// a request dropped while waiting is cancelled, not queued
				if (!req_active) begin
					state_next = HS_IDLE;
				end else if (hclk_rise && hold_cnt_reg == ASYNC_HOLD_EDGES) begin
					do_access  = 1'b1;
					state_next = HS_DONE;
				end
			end
			HS_DONE: begin
				if (!req_active) begin
					state_next = HS_IDLE;
				end
			end
			default: begin
				state_next = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= HS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// edges seen while waiting in resynchronizing mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_cnt_reg <= 2'h0;
		end else if (state_reg != HS_WAIT) begin
			hold_cnt_reg <= 2'h0;
		end else if (hclk_rise && hold_cnt_reg != ASYNC_HOLD_EDGES) begin
			hold_cnt_reg <= hold_cnt_reg + 2'h1;
		end
	end

	// byte lane addressing
	logic [7:0] base_addr;
	logic       do_write;
	logic       do_read;

	assign base_addr = wide_bus ? {addr_s[7:1], 1'b0} : addr_s;
	assign do_write  = do_access & ~ctrl_s.rd_wr;
	assign do_read   = do_access & ctrl_s.rd_wr;

	// channel region bounds and the byte index within one channel copy
	function automatic logic in_chan_region(input logic [7:0] a);
		in_chan_region = (a >= CH_FIRST_ADDR) && (a <= CH_LAST_ADDR);
	endfunction

	function automatic logic [CH_IDXW-1:0] chan_index(input logic [7:0] a);
		logic [7:0] d;
		d = a - CH_FIRST_ADDR;
		chan_index = d[CH_IDXW-1:0];
	endfunction

	// lowest-numbered selected channel for reads
	logic [2:0] read_chan;
	always_comb begin
		read_chan = 3'h0;
		for (int c = NCH - 1; c >= 0; c--) begin
			if (chan_acc_reg[c]) begin
				read_chan = 3'(c);
			end
		end
	end

	function automatic logic [7:0] read_byte(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (in_chan_region(a)) begin
			if (|chan_acc_reg) begin
				v = chan_mem[read_chan][chan_index(a)];
			end
		end else begin
			case (a)
				CHIP_CFG_ADDR: v = chip_cfg_reg;
				CHAN_ACC_ADDR: v = {2'h0, chan_acc_reg};
				CHAN_EN_ADDR:  v = {2'h0, chan_en_reg};
				PIN_CFG_ADDR:  v = pin_cfg_reg;
				default:       v = 8'h00;
			endcase
		end
		read_byte = v;
	endfunction

	// global registers, written lane by lane
	// in 16-bit mode the odd byte of a pair rides on the upper data lines
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chip_cfg_reg <= CHIP_CFG_RESET;
			chan_acc_reg <= CHAN_ACC_RESET;
			chan_en_reg  <= CHAN_EN_RESET;
			pin_cfg_reg  <= PIN_CFG_RESET;
		end else if (do_write) begin
			for (int l = 0; l < 2; l++) begin
				if (l == 0 || wide_bus) begin
					case (base_addr | 8'(l))
						CHIP_CFG_ADDR: chip_cfg_reg <= data_s[8*l +: 8] & 8'(CHIP_CFG_MASK);
						CHAN_ACC_ADDR: chan_acc_reg <= data_s[8*l +: NCH];
						CHAN_EN_ADDR:  chan_en_reg  <= data_s[8*l +: NCH];
						PIN_CFG_ADDR:  pin_cfg_reg  <= data_s[8*l +: 8];
						default: begin
						end
					endcase
				end
			end
		end
	end

	// per-channel copies of the channel register region
	always_ff @(posedge clk) begin
		if (do_write) begin
			for (int c = 0; c < NCH; c++) begin
				for (int l = 0; l < 2; l++) begin
					if ((l == 0 || wide_bus) && chan_acc_reg[c]
						&& in_chan_region(base_addr | 8'(l))) begin
						chan_mem[c][chan_index(base_addr | 8'(l))] <= data_s[8*l +: 8];
					end
				end
			end
		end
	end

	// host read data, held until the next read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_data_out <= 16'h0000;
		end else if (do_read) begin
			host_data_out <= {wide_bus ? read_byte(base_addr | 8'h01) : 8'h00,
				read_byte(base_addr)};
		end
	end

	// the bus is driven from a read's answer until its request drops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_data_oe <= 1'b0;
		end else if (do_read) begin
			host_data_oe <= 1'b1;
		end else if (state_next != HS_DONE) begin
			host_data_oe <= 1'b0;
		end
	end

	// ack stands while the accepted request is still held
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_ack <= 1'b0;
		end else begin
			host_ack <= (state_next == HS_DONE);
		end
	end

	assign channel_enable = chan_en_reg;

	// alignment pin events
	logic [NUM_PINS-1:0] pin_ev;
	logic [NUM_PINS-1:0] pin_ok;
	logic [NCH-1:0]      ch_ev;
	logic                first_seen_reg;
	logic                accept;
	logic                first_only;

	pin_event_detect #(
		.N(NUM_PINS)
	) u_pin_detect (
		.clk       (clk),
		.rst       (rst),
		.pins      ({align_input_3, align_input_2, align_input_1, align_input_0}),
		.edge_mode (pin_cfg_reg[EDGE_MODE_BIT]),
		.events    (pin_ev)
	);

	assign pin_ok     = pin_ev & pin_cfg_reg[PIN_EN_MSB:PIN_EN_LSB];
	assign first_only = pin_cfg_reg[FIRST_ONLY_BIT];
	assign accept     = ~(first_only & first_seen_reg);

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			assign ch_ev[g] = chan_pin_sync_on[g]
				& pin_ok[chan_pin_select[g*PIN_SELW +: PIN_SELW]];
		end
	endgenerate

	// remembers that the first event was taken while first-only is set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_seen_reg <= 1'b0;
		end else if (!first_only) begin
			first_seen_reg <= 1'b0;
		end else if (|ch_ev) begin
			first_seen_reg <= 1'b1;
		end
	end

	// start pulses are masked by the channel enables, hop pulses are not
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hop_pulse   <= '0;
			start_pulse <= '0;
		end else begin
			hop_pulse   <= (accept && pin_cfg_reg[HOP_EN_BIT]) ? ch_ev : '0;
			start_pulse <= (accept && pin_cfg_reg[START_EN_BIT])
				? (ch_ev & chan_en_reg) : '0;
		end
	end

endmodule
`default_nettype wire

// ### rtl/access_sync_pkg.sv
// package for the global access and pin alignment control block
// assumes a 10 MHz core clock and a host port sampled by that clock
package access_sync_pkg;

	// sizes
	localparam int NUM_CH   = 6;
	localparam int NUM_PINS = 4;
	localparam int PIN_SELW = 2;

	// global register byte addresses
	localparam logic [7:0] CHIP_CFG_ADDR = 8'h01;
	localparam logic [7:0] CHAN_ACC_ADDR = 8'h02;
	localparam logic [7:0] CHAN_EN_ADDR  = 8'h03;
	localparam logic [7:0] PIN_CFG_ADDR  = 8'h04;

	// channel register region
	localparam logic [7:0] CH_FIRST_ADDR = 8'h68;
	localparam logic [7:0] CH_LAST_ADDR  = 8'hBB;
	localparam int         CH_DEPTH      = 84;
	localparam int         CH_IDXW       = 7;

	// values after reset
	localparam logic [7:0] CHIP_CFG_RESET = 8'h00;
	localparam logic [5:0] CHAN_ACC_RESET = 6'h00;
	localparam logic [5:0] CHAN_EN_RESET  = 6'h00;
	localparam logic [7:0] PIN_CFG_RESET  = 8'h00;

	// host_port_access_config fields
	localparam int SYNC_PORT_BIT = 7;
	localparam int ID_MSB        = 5;
	localparam int ID_LSB        = 2;
	localparam int WIDE_BUS_BIT  = 0;
	localparam int CHIP_CFG_MASK = 8'hBD;

	// pin_alignment_config fields
	localparam int HOP_EN_BIT     = 7;
	localparam int START_EN_BIT   = 6;
	localparam int FIRST_ONLY_BIT = 5;
	localparam int EDGE_MODE_BIT  = 4;
	localparam int PIN_EN_MSB     = 3;
	localparam int PIN_EN_LSB     = 0;

	// host clock edges counted while waiting, before the access edge, in resynchronizing mode
	localparam logic [1:0] ASYNC_HOLD_EDGES = 2'h1;

	// host control pins, all active low except rd_wr (1 = read)
	typedef struct packed {
		logic rd_wr;
		logic strobe_n;
		logic select_n;
	} host_ctrl_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_WAIT = 3'b010,
		HS_DONE = 3'b100
	} host_state_t;

endpackage

// ### rtl/pin_event_detect.sv
// alignment pin synchronizers with edge or level event detection
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pin_event_detect
	import access_sync_pkg::*;
#(
	parameter int N = NUM_PINS
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// pins and mode
	input  wire logic [N-1:0] pins,
	input  wire logic         edge_mode,
	// detected events
	output var  logic [N-1:0] events
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			logic meta_reg;
			logic sync_reg;
			logic last_reg;
			logic event_reg;
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					meta_reg  <= 1'b0;
					sync_reg  <= 1'b0;
					last_reg  <= 1'b0;
					event_reg <= 1'b0;
				end else begin
					meta_reg  <= pins[i];
					sync_reg  <= meta_reg;
					last_reg  <= sync_reg;
					event_reg <= edge_mode ? (sync_reg & ~last_reg) : sync_reg;
				end
			end
			assign events[i] = event_reg;
		end
	endgenerate
endmodule
`default_nettype wire

// ### rtl/host_port_sync.sv
// two-flop synchronizers for the host port pins plus host clock edge finder
// assumes all host pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module host_port_sync
	import access_sync_pkg::*;
#(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// raw pins
	input  wire logic         host_side_clock,
	input  wire logic [W-1:0] pins_in,
	// synchronized copies
	output var  logic [W-1:0] pins_sync,
	output var  logic         host_clk_rise
);
	logic [W-1:0] meta_reg;
	logic [2:0]   hclk_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg  <= '0;
			pins_sync <= '0;
		end else begin
			meta_reg  <= pins_in;
			pins_sync <= meta_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hclk_reg      <= 3'h0;
			host_clk_rise <= 1'b0;
		end else begin
			hclk_reg      <= {hclk_reg[1:0], host_side_clock};
			host_clk_rise <= hclk_reg[1] & ~hclk_reg[2];
		end
	end
endmodule
`default_nettype wire

// ### dv/global_access_sync_control_props.sv
// checker for host handshake and alignment pulse outputs
// assumes it is bound into global_access_sync_control
`timescale 1ns/1ps
`default_nettype none
module global_access_sync_control_props
	import access_sync_pkg::*;
#(
	parameter int NCH = NUM_CH
) (
	// clock and reset
	input wire logic           clk,
	input wire logic           rst,
	// host port
	input wire host_ctrl_t     host_ctrl,
	input wire logic [15:0]    host_data_out,
	input wire logic           host_data_oe,
	input wire logic           host_ack,
	// alignment
	input wire logic           align_input_0,
	input wire logic           align_input_1,
	input wire logic           align_input_2,
	input wire logic           align_input_3,
	input wire logic [NCH-1:0] chan_pin_sync_on,
	input wire logic [NCH-1:0] channel_enable,
	input wire logic [NCH-1:0] hop_pulse,
	input wire logic [NCH-1:0] start_pulse
);
	// any alignment pin high in the last six cycles
	logic [5:0] pin_hist_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_hist_reg <= 6'h00;
		end else begin
			pin_hist_reg <= {pin_hist_reg[4:0], align_input_0 | align_input_1 | align_input_2 | align_input_3};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence req_held;
		!host_ctrl.select_n && !host_ctrl.strobe_n;
	endsequence
	a_ack_needs_req: assert property ($rose(host_ack) |-> req_held) else $error("ack without request");
	a_oe_on_read: assert property ($rose(host_ack) |-> host_data_oe == host_ctrl.rd_wr) else $error("oe mismatch");
	a_oe_with_ack: assert property (host_data_oe |-> host_ack) else $error("oe without ack");
	a_ack_release: assert property ($rose(host_ctrl.strobe_n) |-> ##[1:6] !host_ack) else $error("ack stuck");
	a_idle_quiet: assert property (host_ctrl.select_n [*6] |-> !host_ack && !host_data_oe) else $error("idle ack");
	a_data_stable: assert property (host_data_oe && $past(host_data_oe) |-> $stable(host_data_out)) else $error("data moved");
	a_start_gated: assert property (start_pulse != '0 |-> (start_pulse & ~channel_enable) == '0) else $error("start on disabled");
	a_sync_selected: assert property (((hop_pulse | start_pulse) & ~chan_pin_sync_on) == '0) else $error("unselected pulse");
	a_pulse_cause: assert property (hop_pulse != '0 |-> pin_hist_reg != 6'h00) else $error("pulse without pin");
	a_reset_quiet: assert property ($fell(rst) |-> channel_enable == '0 && !host_ack) else $error("reset state");
endmodule
bind global_access_sync_control global_access_sync_control_props #(.NCH(NCH)) props_i (
	.clk(clk), .rst(rst), .host_ctrl(host_ctrl), .host_data_out(host_data_out),
	.host_data_oe(host_data_oe), .host_ack(host_ack), .align_input_0(align_input_0),
	.align_input_1(align_input_1), .align_input_2(align_input_2), .align_input_3(align_input_3),
	.chan_pin_sync_on(chan_pin_sync_on), .channel_enable(channel_enable),
	.hop_pulse(hop_pulse), .start_pulse(start_pulse));
`default_nettype wire

// ### dv/host_model.sv
// host processor model on the parallel host port
// assumes clk is the device core clock; the host clock runs free
`timescale 1ns/1ps
`default_nettype none
module host_model
	import access_sync_pkg::*;
(
	// core clock and answers
	input  wire logic        clk,
	input  wire logic        host_ack,
	input  wire logic [15:0] host_data_out,
	// host drive
	output var  logic        host_side_clock,
	output var  host_ctrl_t  host_ctrl,
	output var  logic [7:0]  host_addr,
	output var  logic [15:0] host_data_in
);
	initial begin
		host_side_clock = 1'b0;
		host_ctrl = '{1'b1, 1'b1, 1'b1};
		host_addr = 8'h00;
		host_data_in = 16'h0000;
		#137;
		forever #400 host_side_clock = ~host_side_clock;
	end
	// n reaches 60 when no ack came; released lines carry inverted values
	task automatic access(input logic rd, input logic [7:0] a, input logic [15:0] d,
			output logic [15:0] q, output int n);
		n = 0;
		@(posedge clk) #1;
		host_ctrl = '{rd, 1'b0, 1'b0};
		host_addr = a;
		host_data_in = d;
		do begin
			@(posedge clk);
			n++;
		end while (host_ack !== 1'b1 && n < 60);
		q = host_data_out;
		#1;
		host_ctrl = '{1'b1, 1'b1, 1'b1};
		host_addr = ~a;
		host_data_in = ~d;
		repeat (8) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// ### dv/tb_global_access_sync_control.sv
// testbench for global access and pin alignment control
// assumes host_model drives the host port
`timescale 1ns/1ps
`default_nettype none
module tb_global_access_sync_control;
	import access_sync_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] id_pins = 4'h0;
	logic [3:0] align = 4'h0;
	logic [5:0] sync_on = 6'h3F;
	logic [11:0] pin_sel = 12'h4E4; // channel c listens to pin c mod 4
	logic hsc, ack, oe;
	host_ctrl_t ctrl;
	logic [7:0] addr;
	logic [15:0] din, dout;
	logic [5:0] en, hop, start;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #50 clk = ~clk;
	host_model hm (.clk(clk), .host_ack(ack), .host_data_out(dout), .host_side_clock(hsc),
		.host_ctrl(ctrl), .host_addr(addr), .host_data_in(din));
	global_access_sync_control DUT (.clk(clk), .rst(rst), .host_side_clock(hsc),
		.host_ctrl(ctrl), .host_addr(addr), .host_data_in(din), .host_data_out(dout),
		.host_data_oe(oe), .host_ack(ack), .device_identity_pins(id_pins),
		.align_input_0(align[0]), .align_input_1(align[1]), .align_input_2(align[2]),
		.align_input_3(align[3]), .chan_pin_sync_on(sync_on), .chan_pin_select(pin_sel),
		.channel_enable(en), .hop_pulse(hop), .start_pulse(start));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		int n;
		hm.access(1'b0, a, d, q, n);
		chk(16'(n < 60), 16'h0001);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] q;
		int n;
		hm.access(1'b1, a, 16'h0000, q, n);
		chk(q, e);
	endtask
	task automatic t_modes;
		logic [15:0] q;
		int na, ns;
		@(posedge hsc);
		hm.access(1'b1, CHAN_EN_ADDR, 16'h0000, q, na);
		wr(CHIP_CFG_ADDR, 16'h00C2);
		rd(CHIP_CFG_ADDR, 16'h0080);
		@(posedge hsc);
		hm.access(1'b1, CHAN_EN_ADDR, 16'h0000, q, ns);
		chk(16'(ns + 6 < na), 16'h0001);
	endtask
	task automatic t_identity;
		logic [15:0] q;
		int n;
		wr(CHIP_CFG_ADDR, 16'h00A4);
		id_pins = 4'h9;
		rd(CHIP_CFG_ADDR, 16'h00A4);
		id_pins = 4'h0;
		hm.access(1'b1, CHIP_CFG_ADDR, 16'h0000, q, n);
		chk(16'(n), 16'h003C);
		id_pins = 4'h9;
		wr(CHIP_CFG_ADDR, 16'h0080);
		id_pins = 4'h0;
	endtask
	task automatic t_width;
		wr(CHAN_ACC_ADDR, 16'hFF15);
		rd(CHAN_ACC_ADDR, 16'h0015);
		wr(CHIP_CFG_ADDR, 16'h0081);
		wr(CHAN_ACC_ADDR, 16'h0A21);
		rd(CHAN_EN_ADDR, 16'h0A21);
		wr(8'h00, 16'h8000);
		rd(CHAN_EN_ADDR, 16'h000A);
	endtask
	task automatic t_steer;
		wr(CHAN_ACC_ADDR, 16'h0014);
		wr(8'h70, 16'h00A5);
		wr(CHAN_ACC_ADDR, 16'h0004);
		wr(8'h70, 16'h003C);
		wr(CHAN_ACC_ADDR, 16'h0010);
		rd(8'h70, 16'h00A5);
		wr(CHAN_ACC_ADDR, 16'h0014);
		rd(8'h70, 16'h003C);
		wr(CHAN_ACC_ADDR, 16'h0000);
		rd(8'h70, 16'h0000);
		rd(8'h60, 16'h0000);
	endtask
	// raise pin p for len cycles and collect pulses over a fixed window
	task automatic fire(input int p, input int len, input logic [5:0] eh, input logic [5:0] es,
			input int nh);
		logic [5:0] sh, ss;
		int c;
		sh = 6'h00;
		ss = 6'h00;
		c = 0;
		align[p] = 1'b1;
		for (int i = 0; i < 14; i++) begin
			if (i == len) align[p] = 1'b0;
			@(posedge clk);
			sh |= hop;
			ss |= start;
			c += (hop != 6'h00);
			#1;
		end
		chk(16'(sh), 16'(eh));
		chk(16'(ss), 16'(es));
		chk(16'(c), 16'(nh));
	endtask
	task automatic t_align;
		wr(CHAN_EN_ADDR, 16'h0001);
		chk(16'(en), 16'h0001);
		wr(PIN_CFG_ADDR, 16'h00D1);
		fire(0, 2, 6'h11, 6'h01, 1);
		fire(1, 2, 6'h00, 6'h00, 0);
		wr(PIN_CFG_ADDR, 16'h0013);
		fire(1, 2, 6'h00, 6'h00, 0);
		wr(PIN_CFG_ADDR, 16'h00C1);
		fire(0, 5, 6'h11, 6'h01, 5);
		wr(PIN_CFG_ADDR, 16'h00F1);
		fire(0, 2, 6'h11, 6'h01, 1);
		fire(0, 2, 6'h00, 6'h00, 0);
		wr(PIN_CFG_ADDR, 16'h00D1);
		fire(0, 2, 6'h11, 6'h01, 1);
		sync_on = 6'h2F;
		fire(0, 2, 6'h01, 6'h01, 1);
		sync_on = 6'h3F;
	endtask
	// reset in mid-run must clear the enables and the host port setup
	task automatic t_reset;
		@(posedge clk);
		#1;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		chk(16'(en), 16'(CHAN_EN_RESET));
		repeat (4) @(posedge clk);
		#1;
		rd(CHAN_EN_ADDR, 16'(CHAN_EN_RESET));
		rd(CHIP_CFG_ADDR, 16'(CHIP_CFG_RESET));
	endtask
	task automatic wrap_up;
		if (failures == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge clk);
		rd(CHIP_CFG_ADDR, 16'(CHIP_CFG_RESET));
		rd(CHAN_ACC_ADDR, 16'(CHAN_ACC_RESET));
		rd(CHAN_EN_ADDR, 16'(CHAN_EN_RESET));
		rd(PIN_CFG_ADDR, 16'(PIN_CFG_RESET));
		t_modes();
		t_identity();
		t_width();
		t_steer();
		t_align();
		t_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
